// ===== verilog/sio_pkg.sv
// Shared constants, types and helper functions for the soft core I/O port ends
`default_nettype none
package sio_pkg;
    // Widths and sizes
    localparam int DATA_W = 8;
    localparam int PC_W = 10;
    localparam int NUM_REGS = 16;
    localparam int STACK_DEPTH = 31;
    localparam int SP_W = 5;
    localparam int FIFO_W = 8;
    localparam int FIFO_DEPTH = 16;

    // Reset and event values
    localparam logic [PC_W-1:0] RESET_PC = 10'h000;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 10'h3ff;
    localparam logic [SP_W-1:0] RESET_SP = 5'h00;
    localparam logic [SP_W-1:0] SP_LAST = 5'h1e;

    // Timing counts in clock cycles
    localparam int RESET_MIN_CYCLES = 1;
    localparam int IRQ_MIN_CYCLES = 2;
    localparam int IO_HOLD_CYCLES = 2;

    // Peripheral port map
    localparam logic [7:0] PORT_FIFO_DATA = 8'h00;
    localparam logic [7:0] PORT_FIFO_STAT = 8'h01;
    localparam logic [7:0] PORT_SINK = 8'h02;
    localparam logic [7:0] PORT_LOOP = 8'h03;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Status port bit positions
    localparam int STAT_EMPTY_BIT = 0;
    localparam int STAT_FULL_BIT = 1;
    localparam int STAT_IRQ_BIT = 2;

    // Operations that the command port accepts
    typedef enum logic [2:0] {
        SIO_OP_NOP = 3'h0,
        SIO_OP_LOAD = 3'h1,
        SIO_OP_ADD = 3'h2,
        SIO_OP_INPUT = 3'h3,
        SIO_OP_OUTPUT = 3'h4,
        SIO_OP_EINT = 3'h5,
        SIO_OP_DINT = 3'h6,
        SIO_OP_RETI = 3'h7
    } sio_op_t;

    // Core sequencer states, one bit changing on each step away from idle, two on each return to it
    typedef enum logic [2:0] {
        SIO_ST_IDLE = 3'h0,
        SIO_ST_EXEC1 = 3'h1,
        SIO_ST_EXEC2 = 3'h3,
        SIO_ST_INT1 = 3'h2,
        SIO_ST_INT2 = 3'h6
    } sio_state_t;

    // Cyclic stack pointer step up
    function automatic logic [SP_W-1:0] sp_inc(input logic [SP_W-1:0] sp);
        sp_inc = (sp == SP_LAST) ? RESET_SP : SP_W'(sp + 5'h01);
    endfunction

    // Cyclic stack pointer step down
    function automatic logic [SP_W-1:0] sp_dec(input logic [SP_W-1:0] sp);
        sp_dec = (sp == RESET_SP) ? SP_LAST : SP_W'(sp - 5'h01);
    endfunction
endpackage
`default_nettype wire

// ===== verilog/sio_port_if.sv
// Interface joining the core end and the peripheral end of the I/O port
`default_nettype none
interface sio_port_if;
    logic [7:0] port_address_bus;
    logic [7:0] in_data;
    logic [7:0] out_data;
    logic read_strobe;
    logic write_strobe;
    logic irq;
    logic irq_ack;

    modport core (
        output port_address_bus,
        output out_data,
        output read_strobe,
        output write_strobe,
        output irq_ack,
        input in_data,
        input irq
    );

    modport periph (
        input port_address_bus,
        input out_data,
        input read_strobe,
        input write_strobe,
        input irq_ack,
        output in_data,
        output irq
    );
endinterface
`default_nettype wire

// ===== verilog/sio_core_end.sv
// Core end: two-cycle I/O sequencer with interrupt and reset events
`default_nettype none
// Function
// [RQ1] Capture input bus into target register
// [RQ2] Peripheral drives valid input data meanwhile
// [RQ3] Interrupt request held two cycles minimum
// [RQ4] Interrupt input ignored unless enable flag set
// [RQ5] Reset needs one cycle high
// [RQ6] Self reset after configuration
// [RQ7] All storage on rising edge
// [RQ8] Output data held two cycles
// [RQ9] Port address held two cycles
// [RQ10] Read strobe in second input cycle
// [RQ11] Write strobe in second output cycle
// [RQ12] Peripheral loads output on write strobe
// [RQ13] Acknowledge in second interrupt cycle
// [RQ14] Read strobe may pop a FIFO
// [RQ15] Acknowledge may clear the pending request
// [RQ16] Interrupt saves flags, stacks PC, vectors
// [RQ17] Reset clears PC, flags, enable, stack
// [RQ18] Port number from immediate or register
// [RQ19] Strobes one cycle, low in reset
module sio_core_end (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic CMD_VALID_IN,
    input wire sio_pkg::sio_op_t CMD_OP_IN,
    input wire logic [3:0] CMD_REG_IN,
    input wire logic [3:0] CMD_SRC_IN,
    input wire logic [7:0] CMD_IMM_IN,
    input wire logic CMD_INDIRECT_IN,
    output logic CMD_READY_OUT,
    output logic [9:0] PC_OUT,
    output logic IE_OUT,
    output logic ZERO_OUT,
    output logic CARRY_OUT,
    sio_port_if.core bus
);
    // Whole state of the core end
    typedef struct packed {
        sio_pkg::sio_state_t fsm;
        sio_pkg::sio_op_t op;
        logic [3:0] dst;
        logic [7:0] imm;
        logic [7:0] port_addr;
        logic [7:0] out_data;
        logic [sio_pkg::PC_W-1:0] pc;
        logic zero;
        logic carry;
        logic ie;
        logic save_zero;
        logic save_carry;
        logic [sio_pkg::SP_W-1:0] sp;
        logic [sio_pkg::STACK_DEPTH-1:0][sio_pkg::PC_W-1:0] stack;
        logic [sio_pkg::NUM_REGS-1:0][7:0] regs;
        logic booted;
    } sio_core_t;

    // The all-zero configuration value leaves booted clear, so the first edge is a reset
    sio_core_t st = '0; // [RQ6]
    sio_core_t next_st;
    logic in_reset;
    logic irq_take;
    logic [8:0] add_sum;

    // External reset or the one that follows configuration
    assign in_reset = RST_IN || !st.booted; // [RQ5] [RQ6]

    // Request line only counts while the enable flag is set
    assign irq_take = st.ie && bus.irq; // [RQ4]

    // Sum for the add operation, carry in bit 8
    assign add_sum = {1'b0, st.regs[st.dst]} + {1'b0, st.imm};

    // Next-state logic
    always_comb begin
        next_st = st;
        next_st.booted = 1'b1;
        case (st.fsm)
            sio_pkg::SIO_ST_IDLE: begin
                // Interrupts win over a waiting command at the instruction boundary
                if (irq_take) begin // [RQ4]
                    next_st.fsm = sio_pkg::SIO_ST_INT1;
                end else if (CMD_VALID_IN) begin
                    next_st.fsm = sio_pkg::SIO_ST_EXEC1;
                    next_st.op = CMD_OP_IN;
                    next_st.dst = CMD_REG_IN;
                    next_st.imm = CMD_IMM_IN;
                    // Address and data change only for I/O, keeping the bus quiet otherwise
                    if (CMD_OP_IN == sio_pkg::SIO_OP_INPUT ||
                        CMD_OP_IN == sio_pkg::SIO_OP_OUTPUT) begin
                        next_st.port_addr = CMD_INDIRECT_IN ?
                            st.regs[CMD_SRC_IN] : CMD_IMM_IN; // [RQ9] [RQ18]
                    end
                    if (CMD_OP_IN == sio_pkg::SIO_OP_OUTPUT) begin
                        next_st.out_data = st.regs[CMD_REG_IN]; // [RQ8]
                    end
                end
            end
            sio_pkg::SIO_ST_EXEC1: begin
                next_st.fsm = sio_pkg::SIO_ST_EXEC2;
                // Capture at the end of the first cycle, so the strobe marks a done read
                if (st.op == sio_pkg::SIO_OP_INPUT) begin
                    next_st.regs[st.dst] = bus.in_data; // [RQ1] [RQ2]
                end
            end
            sio_pkg::SIO_ST_EXEC2: begin
                next_st.fsm = sio_pkg::SIO_ST_IDLE;
                next_st.pc = sio_pkg::PC_W'(st.pc + 10'h001);
                case (st.op)
                    sio_pkg::SIO_OP_LOAD: begin
                        next_st.regs[st.dst] = st.imm;
                    end
                    sio_pkg::SIO_OP_ADD: begin
                        next_st.regs[st.dst] = add_sum[7:0];
                        next_st.carry = add_sum[8];
                        next_st.zero = (add_sum[7:0] == 8'h00);
                    end
                    sio_pkg::SIO_OP_EINT: begin
                        next_st.ie = 1'b1;
                    end
                    sio_pkg::SIO_OP_DINT: begin
                        next_st.ie = 1'b0;
                    end
                    sio_pkg::SIO_OP_RETI: begin
                        // Return to the preempted address, restore flags, pick enable
                        next_st.sp = sio_pkg::sp_dec(st.sp);
                        next_st.pc = st.stack[sio_pkg::sp_dec(st.sp)];
                        next_st.zero = st.save_zero;
                        next_st.carry = st.save_carry;
                        next_st.ie = st.imm[0];
                    end
                    default: begin
                        next_st.op = st.op;
                    end
                endcase
            end
            sio_pkg::SIO_ST_INT1: begin
                next_st.fsm = sio_pkg::SIO_ST_INT2;
            end
            sio_pkg::SIO_ST_INT2: begin
                // Full stack overwrites the oldest entry; software must keep one free
                next_st.fsm = sio_pkg::SIO_ST_IDLE;
                next_st.save_zero = st.zero; // [RQ16]
                next_st.save_carry = st.carry; // [RQ16]
                next_st.ie = 1'b0; // [RQ16]
                next_st.stack[st.sp] = st.pc; // [RQ16]
                next_st.sp = sio_pkg::sp_inc(st.sp); // [RQ16]
                next_st.pc = sio_pkg::IRQ_VECTOR; // [RQ16]
            end
            default: begin
                next_st.fsm = sio_pkg::SIO_ST_IDLE;
            end
        endcase
        // Reset event: registers and their contents survive on purpose
        if (in_reset) begin
            next_st.fsm = sio_pkg::SIO_ST_IDLE; // [RQ17]
            next_st.op = sio_pkg::SIO_OP_NOP;
            next_st.pc = sio_pkg::RESET_PC; // [RQ17]
            next_st.zero = 1'b0; // [RQ17]
            next_st.carry = 1'b0; // [RQ17]
            next_st.save_zero = 1'b0;
            next_st.save_carry = 1'b0;
            next_st.ie = 1'b0; // [RQ17]
            next_st.sp = sio_pkg::RESET_SP; // [RQ17]
            next_st.port_addr = 8'h00;
            next_st.out_data = 8'h00;
        end
    end

    // Single rising-edge register; works at any rate down to a stopped clock
    always_ff @(posedge CLK_IN) begin
        st <= next_st; // [RQ7]
    end

    // Strobes decode the second cycle and are forced low during reset
    assign bus.read_strobe = !in_reset && st.fsm == sio_pkg::SIO_ST_EXEC2 &&
        st.op == sio_pkg::SIO_OP_INPUT; // [RQ10] [RQ19]
    assign bus.write_strobe = !in_reset && st.fsm == sio_pkg::SIO_ST_EXEC2 &&
        st.op == sio_pkg::SIO_OP_OUTPUT; // [RQ11] [RQ19]
    assign bus.irq_ack = !in_reset && st.fsm == sio_pkg::SIO_ST_INT2; // [RQ13] [RQ19]

    // Address and data come straight from flops and stand through both cycles
    assign bus.port_address_bus = st.port_addr; // [RQ9]
    assign bus.out_data = st.out_data; // [RQ8]

    // Command handshake and status
    assign CMD_READY_OUT = !in_reset && st.fsm == sio_pkg::SIO_ST_IDLE && !irq_take;
    assign PC_OUT = st.pc;
    assign IE_OUT = st.ie;
    assign ZERO_OUT = st.zero;
    assign CARRY_OUT = st.carry;
endmodule
`default_nettype wire

// ===== verilog/sio_periph_end.sv
// Peripheral end: source FIFO behind input ports, sink port and interrupt source
`default_nettype none
module sio_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic s_valid_in,
    input wire logic [W-1:0] s_data_in,
    output logic s_ready_out,
    output logic m_valid_out,
    output logic [W-1:0] m_data_out,
    input wire logic m_ready_in
);
    localparam int AW = $clog2(DEPTH);

    // Storage and pointers, one spare bit tells full from empty
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
    } sio_fifo_t;

    sio_fifo_t st;
    sio_fifo_t next_st;
    logic full;
    logic empty;

    assign empty = (st.wr == st.rd);
    assign full = (st.wr[AW-1:0] == st.rd[AW-1:0]) && (st.wr[AW] != st.rd[AW]);
    assign s_ready_out = !full;
    assign m_valid_out = !empty;
    assign m_data_out = st.mem[st.rd[AW-1:0]];

    // Push and pop may happen in the same cycle
    always_comb begin
        next_st = st;
        if (s_valid_in && !full) begin
            next_st.mem[st.wr[AW-1:0]] = s_data_in;
            next_st.wr = (AW+1)'(st.wr + 1'b1);
        end
        if (m_ready_in && !empty) begin
            next_st.rd = (AW+1)'(st.rd + 1'b1);
        end
        if (rst_in) begin
            next_st.wr = '0;
            next_st.rd = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        st <= next_st;
    end
endmodule

module sio_periph_end (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic SRC_VALID_IN,
    input wire logic [7:0] SRC_DATA_IN,
    output logic SRC_READY_OUT,
    output logic [7:0] SINK_DATA_OUT,
    output logic SINK_VALID_OUT,
    output logic IRQ_PENDING_OUT,
    sio_port_if.periph bus
);
    // Whole state of the peripheral end
    typedef struct packed {
        logic [7:0] sink_data;
        logic sink_valid;
        logic [7:0] loop_reg;
        logic irq;
    } sio_periph_t;

    sio_periph_t st;
    sio_periph_t next_st;
    logic push;
    logic pop;
    logic fifo_valid;
    logic fifo_ready;
    logic [7:0] fifo_data;
    logic [7:0] status;

    // Reading the data port pops the FIFO; draining only by the core gives back-pressure
    assign pop = bus.read_strobe && bus.port_address_bus == sio_pkg::PORT_FIFO_DATA; // [RQ14]
    assign push = SRC_VALID_IN && fifo_ready;

    sio_fifo #(
        .W(sio_pkg::FIFO_W),
        .DEPTH(sio_pkg::FIFO_DEPTH)
    ) i_sio_fifo (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .s_valid_in(SRC_VALID_IN),
        .s_data_in(SRC_DATA_IN),
        .s_ready_out(fifo_ready),
        .m_valid_out(fifo_valid),
        .m_data_out(fifo_data),
        .m_ready_in(pop)
    );

    always_comb begin
        status = 8'h00;
        status[sio_pkg::STAT_EMPTY_BIT] = !fifo_valid;
        status[sio_pkg::STAT_FULL_BIT] = !fifo_ready;
        status[sio_pkg::STAT_IRQ_BIT] = st.irq;
    end

    // Input mux is combinational so it follows the address within the first cycle
    always_comb begin
        case (bus.port_address_bus)
            sio_pkg::PORT_FIFO_DATA: begin
                bus.in_data = fifo_valid ? fifo_data : sio_pkg::UNMAPPED_READ; // [RQ2]
            end
            sio_pkg::PORT_FIFO_STAT: bus.in_data = status; // [RQ2]
            sio_pkg::PORT_LOOP: bus.in_data = st.loop_reg; // [RQ2]
            default: bus.in_data = sio_pkg::UNMAPPED_READ;
        endcase
    end

    // Write capture, sink pulse and interrupt request
    always_comb begin
        next_st = st;
        next_st.sink_valid = 1'b0;
        if (bus.write_strobe) begin
            if (bus.port_address_bus == sio_pkg::PORT_SINK) begin
                next_st.sink_data = bus.out_data; // [RQ12]
                next_st.sink_valid = 1'b1; // [RQ12]
            end else if (bus.port_address_bus == sio_pkg::PORT_LOOP) begin
                next_st.loop_reg = bus.out_data; // [RQ12]
            end
        end
        // Request stands until acknowledged, which is never sooner than two cycles
        if (bus.irq_ack) begin
            next_st.irq = 1'b0; // [RQ15]
        end
        // A new word in the same cycle as the acknowledge keeps the request up
        if (push) begin
            next_st.irq = 1'b1; // [RQ3]
        end
        if (RST_IN) begin
            next_st = '0; // [RQ5]
        end
    end

    always_ff @(posedge CLK_IN) begin
        st <= next_st;
    end

    assign bus.irq = st.irq; // [RQ3]
    assign SRC_READY_OUT = fifo_ready;
    assign SINK_DATA_OUT = st.sink_data;
    assign SINK_VALID_OUT = st.sink_valid;
    assign IRQ_PENDING_OUT = st.irq;
endmodule
`default_nettype wire

// ===== tb/sio_port_sva.sv
// Checker of the port interface timing between the core end and the peripheral end
`default_nettype none
module sio_port_sva (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic [7:0] port_address_bus,
    input wire logic [7:0] in_data,
    input wire logic [7:0] out_data,
    input wire logic read_strobe,
    input wire logic write_strobe,
    input wire logic irq,
    input wire logic irq_ack
);
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (RST_IN);

    // No strobe and no acknowledge in this cycle
    sequence s_quiet;
        !read_strobe && !write_strobe && !irq_ack;
    endsequence
    // Every operation lasts two cycles, so two quiet cycles follow any pulse
    sequence s_gap;
        s_quiet [*2];
    endsequence

    // Data and address stand through both cycles of an output
    property p_wr_hold;
        write_strobe |-> $stable(out_data);
    endproperty
    property p_addr_hold;
        (read_strobe || write_strobe) |-> $stable(port_address_bus);
    endproperty
    property p_out_after;
        write_strobe |=> $stable(out_data) && $stable(port_address_bus);
    endproperty
    // Pulses are single cycles with the instruction spacing behind them
    property p_rd_pulse;
        read_strobe |=> s_gap;
    endproperty
    property p_wr_pulse;
        write_strobe |=> s_gap;
    endproperty
    property p_ack_pulse;
        irq_ack |=> s_gap;
    endproperty
    // The acknowledge comes two cycles after the request was seen
    property p_ack_cause;
        irq_ack |-> $past(irq, 2) && $past(irq, 1);
    endproperty
    property p_one_kind;
        $onehot0({read_strobe, write_strobe, irq_ack});
    endproperty
    // A new request stands at least one more cycle, as the core needs two to see it
    property p_irq_hold;
        $rose(irq) |=> irq;
    endproperty
    // Leaving reset, the bus is quiet and cleared
    property p_reset_state;
        $fell(RST_IN) |-> s_quiet and (port_address_bus == 8'h00 && out_data == 8'h00);
    endproperty

    a_wr_hold: assert property (p_wr_hold)
        else $error("output data moved under write strobe");
    a_addr_hold: assert property (p_addr_hold)
        else $error("port address moved under strobe");
    a_out_after: assert property (p_out_after)
        else $error("output data or address moved after write strobe");
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("read strobe not a lone pulse");
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("write strobe not a lone pulse");
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("acknowledge not a lone pulse");
    a_ack_cause: assert property (p_ack_cause)
        else $error("acknowledge without request two cycles before");
    a_one_kind: assert property (p_one_kind)
        else $error("two pulses at once");
    a_irq_hold: assert property (p_irq_hold)
        else $error("interrupt request shorter than two cycles");
    a_reset_state: assert property (p_reset_state)
        else $error("bus not cleared after reset");
endmodule
`default_nettype wire

// ===== tb/softcore_io_interrupt_port_test.sv
// Self-checking bench for the core end and the peripheral end joined by the port interface
`default_nettype none
module softcore_io_interrupt_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_ind = 1'b0, src_valid = 1'b0;
    sio_pkg::sio_op_t cmd_op = sio_pkg::SIO_OP_NOP;
    logic [3:0] cmd_reg = 4'h0, cmd_src = 4'h0;
    logic [7:0] cmd_imm = 8'h00, src_data = 8'h00, sink_data, v;
    logic cmd_ready, src_ready, sink_valid, irq_pending, ie, zero, carry;
    logic [9:0] pc, pc_save;
    int error_cnt = 0, compares = 0, cycles = 0, ack_cnt = 0;
    sio_port_if port_if();

    sio_core_end i_sio_core_end (.CLK_IN(clk), .RST_IN(rst), .CMD_VALID_IN(cmd_valid),
        .CMD_OP_IN(cmd_op), .CMD_REG_IN(cmd_reg), .CMD_SRC_IN(cmd_src), .CMD_IMM_IN(cmd_imm),
        .CMD_INDIRECT_IN(cmd_ind), .CMD_READY_OUT(cmd_ready), .PC_OUT(pc), .IE_OUT(ie),
        .ZERO_OUT(zero), .CARRY_OUT(carry), .bus(port_if.core));
    sio_periph_end i_sio_periph_end (.CLK_IN(clk), .RST_IN(rst), .SRC_VALID_IN(src_valid),
        .SRC_DATA_IN(src_data), .SRC_READY_OUT(src_ready), .SINK_DATA_OUT(sink_data),
        .SINK_VALID_OUT(sink_valid), .IRQ_PENDING_OUT(irq_pending), .bus(port_if.periph));
    sio_port_sva chk (.CLK_IN(clk), .RST_IN(rst), .port_address_bus(port_if.port_address_bus),
        .in_data(port_if.in_data), .out_data(port_if.out_data),
        .read_strobe(port_if.read_strobe), .write_strobe(port_if.write_strobe),
        .irq(port_if.irq), .irq_ack(port_if.irq_ack));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    // Cycle ceiling against a hang, and a tally of acknowledge pulses
    always @(posedge clk) begin
        cycles++;
        if (port_if.irq_ack === 1'b1) ack_cnt++;
        if (cycles == 6000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic test_done();
        $display("compares %0d, error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    // Offer one command, wait until taken, return when its effect has landed
    task automatic cmd(input sio_pkg::sio_op_t op, input logic [3:0] r, input logic [3:0] s,
                       input logic [7:0] imm, input logic ind);
        int n;
        n = 0;
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_reg = r;
        cmd_src = s;
        cmd_imm = imm;
        cmd_ind = ind;
        while (cmd_ready !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("cmd_ready", cmd_ready, 1'b1);
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // One word into the source FIFO; an idle edge first keeps back-to-back calls apart
    task automatic push(input logic [7:0] d);
        @(posedge clk);
        #1;
        src_valid = 1'b1;
        src_data = d;
        @(posedge clk);
        #1;
        src_valid = 1'b0;
    endtask

    // Read a port into s1 and copy it to the sink, where the bench can see it
    task automatic rd_port(input logic [7:0] port, output logic [7:0] val);
        cmd(sio_pkg::SIO_OP_INPUT, 4'h1, 4'h0, port, 1'b0);
        cmd(sio_pkg::SIO_OP_OUTPUT, 4'h1, 4'h0, sio_pkg::PORT_SINK, 1'b0);
        check("sink_valid", sink_valid, 1'b1);
        val = sink_data;
    endtask

    task automatic t_after_reset();
        check("pc", pc, 10'h000);
        check("ie", ie, 1'b0);
        check("flags", {zero, carry}, 2'h0);
    endtask

    // FIFO reads, status, loopback through an indirect port, unmapped port
    task automatic t_io();
        push(8'ha1);
        push(8'hb2);
        rd_port(sio_pkg::PORT_FIFO_DATA, v);
        check("fifo head", v, 8'ha1);
        rd_port(sio_pkg::PORT_FIFO_STAT, v);
        check("status", v, 8'h04);
        rd_port(sio_pkg::PORT_FIFO_DATA, v);
        check("fifo head", v, 8'hb2);
        cmd(sio_pkg::SIO_OP_LOAD, 4'h2, 4'h0, sio_pkg::PORT_LOOP, 1'b0);
        cmd(sio_pkg::SIO_OP_LOAD, 4'h3, 4'h0, 8'ha5, 1'b0);
        cmd(sio_pkg::SIO_OP_OUTPUT, 4'h3, 4'h2, 8'h00, 1'b1);
        rd_port(sio_pkg::PORT_LOOP, v);
        check("loopback", v, 8'ha5);
        rd_port(8'h7f, v);
        check("unmapped", v, sio_pkg::UNMAPPED_READ);
        check("pc", pc, 10'h00d);
        check("no ack while disabled", ack_cnt, 0);
    endtask

    // Fill until refused, drain until empty; interrupt stays pending but ignored
    task automatic t_fill();
        for (int i = 0; i < sio_pkg::FIFO_DEPTH; i++) begin
            push(8'h40 + 8'(i));
        end
        check("src_ready full", src_ready, 1'b0);
        push(8'hee);
        rd_port(sio_pkg::PORT_FIFO_STAT, v);
        check("status full", v, 8'h06);
        check("irq pending", irq_pending, 1'b1);
        for (int i = 0; i < sio_pkg::FIFO_DEPTH; i++) begin
            rd_port(sio_pkg::PORT_FIFO_DATA, v);
            check("drain", v, 8'h40 + 8'(i));
        end
        rd_port(sio_pkg::PORT_FIFO_STAT, v);
        check("status empty", v, 8'h05);
        check("no ack while disabled", ack_cnt, 0);
    endtask

    // Flags set, then a one-cycle reset in mid-run; data registers survive
    task automatic t_reset();
        cmd(sio_pkg::SIO_OP_LOAD, 4'h4, 4'h0, 8'hff, 1'b0);
        cmd(sio_pkg::SIO_OP_ADD, 4'h4, 4'h0, 8'h01, 1'b0);
        check("flags", {zero, carry}, 2'h3);
        rst = 1'b1;
        @(posedge clk);
        #1;
        rst = 1'b0;
        check("pc", pc, 10'h000);
        check("flags", {zero, carry}, 2'h0);
        check("src_ready", src_ready, 1'b1);
        rd_port(sio_pkg::PORT_FIFO_STAT, v);
        check("status", v, 8'h01);
        cmd(sio_pkg::SIO_OP_OUTPUT, 4'h3, 4'h0, sio_pkg::PORT_SINK, 1'b0);
        check("register kept", sink_data, 8'ha5);
    endtask

    // Interrupt with flags set, then return with interrupts left off
    task automatic t_irq();
        cmd(sio_pkg::SIO_OP_LOAD, 4'h4, 4'h0, 8'hff, 1'b0);
        cmd(sio_pkg::SIO_OP_ADD, 4'h4, 4'h0, 8'h01, 1'b0);
        cmd(sio_pkg::SIO_OP_EINT, 4'h0, 4'h0, 8'h00, 1'b0);
        check("ie", ie, 1'b1);
        pc_save = pc;
        push(8'h3c);
        check("irq", port_if.irq, 1'b1);
        @(posedge clk);
        #1;
        check("ack early", port_if.irq_ack, 1'b0);
        @(posedge clk);
        #1;
        check("ack", port_if.irq_ack, 1'b1);
        @(posedge clk);
        #1;
        check("vector", pc, sio_pkg::IRQ_VECTOR);
        check("ie", ie, 1'b0);
        check("irq cleared", port_if.irq, 1'b0);
        cmd(sio_pkg::SIO_OP_RETI, 4'h0, 4'h0, 8'h00, 1'b0);
        check("return pc", pc, pc_save);
        check("flags back", {zero, carry}, 2'h3);
        check("ack count", ack_cnt, 1);
    endtask

    // Reset for 8 cycles, then the scenarios in turn
    initial begin
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        t_after_reset();
        t_io();
        t_fill();
        t_reset();
        t_irq();
        test_done();
    end
endmodule
`default_nettype wire
